// ==== mrrtc_pkg.sv ====
// constants and types for the mode register read controller
//------------------------------------------------------------
// How it works
// - read command: cs low, ca 1000 rising
// - read command period is two clocks
// - only no-operation during command period
// - read to write spacing, latency based
// - read to register write, same spacing
// - never overlap an ongoing data burst
// - after read wait half burst length
// - after write wait wl+1+bl/2+wtr
// - use shortened burst length after stop
// - poll often enough for 2 degrees
// - calibration reads only when banks idle
// - every read is four beats, uninterrupted
//------------------------------------------------------------
package mrrtc_pkg;
  // clocking
  localparam int unsigned CLK_KHZ       = 40000;
  localparam int unsigned SYS_PS        = 25000;
  localparam int unsigned CK_DIV        = 2;
  localparam int unsigned TCK_PS        = SYS_PS * CK_DIV;
  localparam int unsigned SYNC_STAGES   = 2;
  // link timing, in link clocks unless stated
  localparam int unsigned RL_CK         = 3;
  localparam int unsigned WL_CK         = 1;
  localparam int unsigned MRR_BL        = 4;
  localparam int unsigned MODE_READ_CMD_PERIOD_CK       = 2;
  localparam int unsigned DQSCK_MAX_PS  = 5500;
  localparam int unsigned WTR_PS        = 7500;
  localparam int unsigned RU_DQSCK      = (DQSCK_MAX_PS + TCK_PS - 1) / TCK_PS;
  localparam int unsigned RU_WTR        = (WTR_PS + TCK_PS - 1) / TCK_PS;
  localparam int unsigned MRR_TO_WR_CK  = RL_CK + RU_DQSCK + MRR_BL / 2 + 1;
  // same figures in system cycles
  localparam logic [7:0]  MODE_READ_CMD_PERIOD_NOP_SYS  = 8'(MODE_READ_CMD_PERIOD_CK * CK_DIV - 3);
  // strobe delay is rounded in system cycles, not link clocks, or the capture lands one beat late
  localparam logic [7:0]  WAIT_SYS      = 8'(RL_CK * CK_DIV + (DQSCK_MAX_PS + SYS_PS - 1) / SYS_PS + SYNC_STAGES - 5);
  localparam logic [7:0]  WR_GAP_SYS    = 8'((WL_CK + 1 + RU_WTR) * CK_DIV);
  localparam logic [15:0] MRR_TO_WR_SYS = 16'(MRR_TO_WR_CK * CK_DIV + 1);
  localparam logic [1:0]  LAST_BEAT     = 2'(MRR_BL - 1);
  // temperature polling
  localparam int unsigned TSI_MS        = 32;
  localparam int unsigned SYS_RESP_MS   = 1;
  localparam int unsigned POLL_MS       = 100;
  localparam logic [2:0]  TEMP_HOT_CODE = 3'h3;
  // pin codes
  localparam logic [3:0]  MRR_CODE      = 4'h8;
  localparam logic [9:0]  NOP_CA        = 10'h003;
  localparam logic [7:0]  MA_TEMP       = 8'h04;
  localparam logic [7:0]  MA_CAL_A      = 8'h20;
  localparam logic [7:0]  MA_CAL_B      = 8'h28;
  localparam logic [3:0]  PAT_A         = 4'h5;
  localparam logic [3:0]  PAT_B         = 4'hC;
  localparam int unsigned DQ_W          = 32;
  localparam int unsigned BYTES         = DQ_W / 8;

  typedef struct packed {
    logic       cs_n;
    logic [9:0] ca;
  } mrrtc_ca_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD_R,
    ST_CMD_F,
    ST_NOP,
    ST_WAIT,
    ST_BURST
  } mrrtc_state_e;
endpackage

// ==== mrrtc_ctrl.sv ====
// controller issuing mode register reads, temperature polls and calibration reads
`timescale 1ns/100ps
module mrrtc_ctrl
  import mrrtc_pkg::*;
#(
  parameter int unsigned POLL_CYCLES = POLL_MS * CLK_KHZ
) (
  // clock, reset, enable
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // read request
  input  wire logic             req_valid_i,
  input  wire logic [7:0]       req_ma_i,
  output logic                  req_ready_o,
  // read answer
  output logic                  rsp_valid_o,
  output logic [7:0]            rsp_data_o,
  output logic                  rsp_err_o,
  output logic                  rsp_cal_ok_o,
  // array traffic notes from the main scheduler
  input  wire logic             rd_cmd_i,
  input  wire logic             wr_cmd_i,
  input  wire logic [4:0]       bl_eff_i,
  input  wire logic             banks_idle_i,
  // spacing status
  output logic                  wr_ok_o,
  output logic                  mrw_ok_o,
  // temperature
  output logic [2:0]            temp_status_o,
  output logic                  temp_hot_o,
  // device pins
  output logic                  ck_t_o,
  output logic                  ck_c_o,
  output mrrtc_ca_s             link_o,
  input  wire logic [DQ_W-1:0]  dq_i,
  input  wire logic [BYTES-1:0] dqs_t_i
);

  mrrtc_state_e          state_reg;
  logic                  ck_reg;
  logic [7:0]            cnt_reg;
  logic [1:0]            beat_reg;
  logic [7:0]            gap_reg;
  logic [15:0]           post_reg;
  logic [31:0]           poll_cnt_reg;
  logic                  poll_pend_reg;
  logic                  poll_expire;
  logic [7:0]            tgt_reg;
  logic                  int_reg;
  logic                  start;
  logic                  accept;
  logic                  reject;
  logic                  done;
  logic [DQ_W-1:0]       dq_s1_reg, dq_s2_reg;
  logic [BYTES-1:0]      dqs_s1_reg, dqs_s2_reg, dqs_prev_reg;
  logic                  dqs_seen_reg;
  logic [7:0]            data_reg;
  logic [3:0]            pat_reg [BYTES];
  logic [BYTES-1:0]      lanes_ok_reg;
  logic [BYTES-1:0]      byte_ok;
  logic [3:0]            pat_exp;
  logic                  is_cal;
  logic [7:0]            wr_gap_next;
  logic                  done_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  //------------------------------------------------------------
  // pin synchronisers
  //------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_s1_reg  <= '0;
      dq_s2_reg  <= '0;
      dqs_s1_reg <= '0;
      dqs_s2_reg <= '0;
    end else if (ce_i) begin
      dq_s1_reg  <= dq_i;
      dq_s2_reg  <= dq_s1_reg;
      dqs_s1_reg <= dqs_t_i;
      dqs_s2_reg <= dqs_s1_reg;
    end
  end

  //------------------------------------------------------------
  // link clock divider
  //------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ck_reg <= 1'b0;
    end else if (ce_i) begin
      ck_reg <= ~ck_reg;
    end
  end

  assign ck_t_o = ck_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ck_c_o <= 1'b1;
    end else if (ce_i) begin
      ck_c_o <= ck_reg;
    end
  end

  //------------------------------------------------------------
  // request decode
  //------------------------------------------------------------
  assign is_cal      = (req_ma_i == MA_CAL_A) || (req_ma_i == MA_CAL_B);
  assign accept      = ce_i && req_valid_i && req_ready_o;
  assign reject      = accept && is_cal && !banks_idle_i;
  assign poll_expire = (poll_cnt_reg == POLL_CYCLES - 1);
  // poll waits for its own launch slot, same phase and gap as a user request
  assign start       = (accept && !reject) ||
                       (ce_i && state_reg == ST_IDLE && poll_pend_reg && ck_reg && gap_reg == 8'h00);
  assign done        = ce_i && state_reg == ST_BURST && beat_reg == LAST_BEAT;
  assign wr_gap_next = WR_GAP_SYS + 8'(bl_eff_i);

  //------------------------------------------------------------
  // spacing after array bursts
  //------------------------------------------------------------
  // read gap, write gap, effective length
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_reg <= 8'h00;
    end else if (ce_i) begin
      if (wr_cmd_i && wr_gap_next > gap_reg) begin
        gap_reg <= wr_gap_next;
      end else if (rd_cmd_i && 8'(bl_eff_i) > gap_reg) begin
        gap_reg <= 8'(bl_eff_i);
      end else if (gap_reg != 8'h00) begin
        gap_reg <= gap_reg - 8'h01;
      end
    end
  end

  ready_gap_a: assert property (req_ready_o |-> gap_reg == 8'h00)
    else $error("ready raised inside burst gap");
  ready_idle_a: assert property (req_ready_o |-> state_reg == ST_IDLE)
    else $error("ready raised outside idle");

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_ready_o <= 1'b0;
    end else if (ce_i) begin
      req_ready_o <= state_reg == ST_IDLE && !ck_reg && gap_reg <= 8'h01 && !rd_cmd_i && !wr_cmd_i &&
                     !poll_pend_reg && !poll_expire && !accept;
    end
  end

  //------------------------------------------------------------
  // sequencer
  //------------------------------------------------------------
  // two clock command period, four beats
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 8'h00;
      beat_reg  <= 2'h0;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_CMD_R;
          end
        end
        ST_CMD_R: begin
          state_reg <= ST_CMD_F;
        end
        ST_CMD_F: begin
          state_reg <= ST_NOP;
          cnt_reg   <= MODE_READ_CMD_PERIOD_NOP_SYS;
        end
        ST_NOP: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= ST_WAIT;
            cnt_reg   <= WAIT_SYS;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_WAIT: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= ST_BURST;
            beat_reg  <= 2'h0;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        ST_BURST: begin
          beat_reg <= beat_reg + 2'h1;
          if (beat_reg == LAST_BEAT) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  sequence burst_s;
    (state_reg == ST_BURST) [*4] ##1 (state_reg == ST_IDLE);
  endsequence
  burst_len_a: assert property ((state_reg == ST_BURST && beat_reg == 2'h0) |-> burst_s)
    else $error("burst not four beats");

  //------------------------------------------------------------
  // command pins
  //------------------------------------------------------------
  // rise half then fall half, no-operation otherwise
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_o <= '{cs_n: 1'b1, ca: NOP_CA};
    end else if (ce_i) begin
      if (start) begin
        link_o <= '{cs_n: 1'b0, ca: {(accept ? req_ma_i[7:2] : MA_TEMP[7:2]), MRR_CODE}};
      end else if (state_reg == ST_CMD_R) begin
        link_o <= '{cs_n: 1'b0, ca: {8'h00, tgt_reg[1:0]}};
      end else begin
        link_o <= '{cs_n: 1'b0, ca: NOP_CA};
      end
    end
  end

  sequence cmd_rise_s;
    !link_o.cs_n && link_o.ca[3:0] == MRR_CODE;
  endsequence
  sequence cmd_tail_s;
    (link_o.ca[9:2] == 8'h00) ##1 (link_o.ca == NOP_CA) [*2];
  endsequence
  cmd_code_a: assert property (start |=> cmd_rise_s)
    else $error("read code missing on pins");
  cmd_period_a: assert property (start |=> cmd_rise_s ##1 cmd_tail_s)
    else $error("command period broken");
  cmd_nop_a: assert property (state_reg == ST_NOP |-> link_o.ca == NOP_CA)
    else $error("command inside read period");

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgt_reg <= 8'h00;
      int_reg <= 1'b0;
    end else if (start) begin
      tgt_reg <= accept ? req_ma_i : MA_TEMP;
      int_reg <= !accept;
    end
  end

  //------------------------------------------------------------
  // spacing after the read command
  //------------------------------------------------------------
  // write spacing, register write spacing
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      post_reg <= 16'h0000;
      wr_ok_o  <= 1'b1;
      mrw_ok_o <= 1'b1;
    end else if (ce_i) begin
      if (start) begin
        post_reg <= MRR_TO_WR_SYS;
      end else if (post_reg != 16'h0000) begin
        post_reg <= post_reg - 16'h0001;
      end
      wr_ok_o  <= post_reg == 16'h0000 && !start;
      mrw_ok_o <= post_reg == 16'h0000 && !start;
    end
  end

  wr_hold_a: assert property (start |=> !wr_ok_o [*8])
    else $error("write allowed too soon");
  mrw_hold_a: assert property (start |=> !mrw_ok_o [*8])
    else $error("register write allowed too soon");

  //------------------------------------------------------------
  // burst capture
  //------------------------------------------------------------
  // only beat zero low byte is data
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_reg     <= 8'h00;
      dqs_prev_reg <= '0;
      dqs_seen_reg <= 1'b0;
    end else if (ce_i) begin
      dqs_prev_reg <= dqs_s2_reg;
      if (start) begin
        dqs_seen_reg <= 1'b0;
      end else if (state_reg == ST_BURST) begin
        dqs_seen_reg <= dqs_seen_reg || (dqs_s2_reg != dqs_prev_reg);
        if (beat_reg == 2'h0) begin
          data_reg <= dq_s2_reg[7:0];
        end
      end
    end
  end

  assign pat_exp = (tgt_reg == MA_CAL_A) ? PAT_A : PAT_B;

  // lane 0 of each byte, every beat
  generate
    for (genvar b = 0; b < BYTES; b++) begin : g_byte
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pat_reg[b]      <= 4'h0;
          lanes_ok_reg[b] <= 1'b1;
        end else if (ce_i) begin
          if (start) begin
            lanes_ok_reg[b] <= 1'b1;
          end else if (state_reg == ST_BURST) begin
            pat_reg[b][beat_reg] <= dq_s2_reg[8*b];
            // copy of lane 0 or zero
            lanes_ok_reg[b] <= lanes_ok_reg[b] &&
                               (dq_s2_reg[8*b+1 +: 7] == {7{dq_s2_reg[8*b]}} || dq_s2_reg[8*b+1 +: 7] == 7'h00);
          end
        end
      end
      assign byte_ok[b] = lanes_ok_reg[b] && (pat_reg[b] == pat_exp);
    end
  endgenerate

  //------------------------------------------------------------
  // answers
  //------------------------------------------------------------
  // answer one cycle after the last beat, so the last pattern bit is in
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_reg     <= 1'b0;
      rsp_valid_o  <= 1'b0;
      rsp_data_o   <= 8'h00;
      rsp_err_o    <= 1'b0;
      rsp_cal_ok_o <= 1'b0;
    end else if (ce_i) begin
      done_reg     <= done;
      rsp_valid_o  <= reject || (done_reg && !int_reg);
      rsp_err_o    <= reject || (done_reg && !int_reg && !dqs_seen_reg);
      rsp_data_o   <= reject ? 8'h00 : data_reg;
      rsp_cal_ok_o <= !reject && done_reg && (tgt_reg == MA_CAL_A || tgt_reg == MA_CAL_B) && (&byte_ok);
    end
  end

  refuse_a: assert property (reject |=> rsp_valid_o && rsp_err_o && link_o.ca == NOP_CA)
    else $error("refused request not answered");

  //------------------------------------------------------------
  // temperature polling
  //------------------------------------------------------------
  // interval sized for the gradient budget
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      poll_cnt_reg  <= 32'h0000_0000;
      poll_pend_reg <= 1'b0;
    end else if (ce_i) begin
      poll_cnt_reg <= poll_expire ? 32'h0000_0000 : poll_cnt_reg + 32'h0000_0001;
      // expiry wins over the launch clear
      if (poll_expire) begin
        poll_pend_reg <= 1'b1;
      end else if (start && !accept) begin
        poll_pend_reg <= 1'b0;
      end
    end
  end

  // status read like any register, hot code
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_status_o <= 3'h0;
      temp_hot_o    <= 1'b0;
    end else if (done && tgt_reg == MA_TEMP) begin
      temp_status_o <= data_reg[2:0];
      temp_hot_o    <= data_reg[2:0] >= TEMP_HOT_CODE;
    end
  end

endmodule

// ==== mrrtc_dev_model.sv ====
// behavioural memory device answering mode register reads
`timescale 1ns/100ps
module mrrtc_dev_model
  import mrrtc_pkg::*;
#(
  parameter real DLY_NS = 3.0
) (
  // link pins
  input  wire logic             ck_t_i,
  input  wire mrrtc_ca_s        pins_i,
  output logic [DQ_W-1:0]       dq_o,
  output logic [BYTES-1:0]      dqs_o,
  // bench controls
  input  wire logic [2:0]       temp_i,
  input  wire logic             mute_i,
  output logic [7:0]            mrr_cnt_o,
  output logic [7:0]            viol_cnt_o
);
  //--------------------------------
  // command decode and burst
  //--------------------------------
  wire mrrtc_ca_s        pins_d;
  logic      [7:0]       ma;
  // latch what stood before the edge; launch and edge coincide
  assign #1 pins_d = pins_i;
  initial begin
    dq_o = '0;
    dqs_o = '0;
    mrr_cnt_o = '0;
    viol_cnt_o = '0;
  end
  function automatic logic [DQ_W-1:0] beat_val(input int b);
    logic [3:0] pat;
    pat = (ma == MA_CAL_A) ? PAT_A : PAT_B;
    if (ma == MA_CAL_A || ma == MA_CAL_B)
      return {DQ_W{pat[b]}};
    if (b == 0)
      return {{(BYTES-1){8'hA5}}, (ma == MA_TEMP) ? {5'h00, temp_i} : ma ^ 8'h3C};
    return {BYTES{8'(b) ^ 8'hC3}};
  endfunction
  always @(posedge ck_t_i) begin
    if (!pins_d.cs_n && pins_d.ca[3:0] == MRR_CODE) begin
      ma[7:2] = pins_d.ca[9:4];
      @(negedge ck_t_i);
      ma[1:0] = pins_d.ca[1:0];
      mrr_cnt_o = mrr_cnt_o + 8'h01;
      @(posedge ck_t_i);
      if (!pins_d.cs_n && pins_d.ca[2:0] != 3'h3)
        viol_cnt_o = viol_cnt_o + 8'h01;
      repeat (RL_CK - 1) @(posedge ck_t_i);
      for (int b = 0; b < MRR_BL; b++) begin
        #(DLY_NS);
        dq_o = beat_val(b);
        if (!mute_i)
          dqs_o = b[0] ? '0 : '1;
        @(ck_t_i);
      end
      #(DLY_NS);
      // released lines never keep the last value
      dq_o = ~dq_o;
      dqs_o = ~dqs_o;
    end
  end
endmodule

// ==== mrrtc_ctrl_bench.sv ====
// self-checking bench for the mode register read controller
`timescale 1ns/100ps
module mrrtc_ctrl_bench;
  import mrrtc_pkg::*;
  //--------------------------------
  // wiring
  //--------------------------------
  localparam int POLL = 300;
  localparam int LIMIT = 20 * POLL + 4000;
  logic             clk_sys_i    = 1'b0;
  logic             rst_n_i      = 1'b0;
  logic             ce_i         = 1'b1;
  logic             req_valid_i  = 1'b0;
  logic [7:0]       req_ma_i     = 8'h00;
  logic             rd_cmd_i     = 1'b0;
  logic             wr_cmd_i     = 1'b0;
  logic [4:0]       bl_eff_i     = 5'h04;
  logic             banks_idle_i = 1'b1;
  logic [2:0]       temp         = 3'h0;
  logic             mute         = 1'b0;
  logic             req_ready_o, rsp_valid_o, rsp_err_o, rsp_cal_ok_o;
  logic             wr_ok_o, mrw_ok_o, temp_hot_o, ck_t_o, ck_c_o;
  logic [7:0]       rsp_data_o, mrr_cnt, viol_cnt;
  logic [2:0]       temp_status_o;
  mrrtc_ca_s        link_o;
  logic [DQ_W-1:0]  dq_i;
  logic [BYTES-1:0] dqs_t_i;
  int err_count = 0, samples_checked = 0;
  int cyc = 0, cmd_cyc = 0, wr_low = 0, mrw_low = 0;

  mrrtc_ctrl #(.POLL_CYCLES(POLL)) dut (.clk_sys_i, .rst_n_i, .ce_i, .req_valid_i, .req_ma_i,
    .req_ready_o, .rsp_valid_o, .rsp_data_o, .rsp_err_o, .rsp_cal_ok_o, .rd_cmd_i, .wr_cmd_i,
    .bl_eff_i, .banks_idle_i, .wr_ok_o, .mrw_ok_o, .temp_status_o, .temp_hot_o, .ck_t_o,
    .ck_c_o, .link_o, .dq_i, .dqs_t_i);
  mrrtc_dev_model model (.ck_t_i(ck_t_o), .pins_i(link_o), .dq_o(dq_i), .dqs_o(dqs_t_i),
    .temp_i(temp), .mute_i(mute), .mrr_cnt_o(mrr_cnt), .viol_cnt_o(viol_cnt));

  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  always @(negedge clk_sys_i) begin
    if (link_o.cs_n === 1'b0 && link_o.ca[3:0] === MRR_CODE)
      cmd_cyc = cyc;
    if (wr_ok_o !== 1'b1)
      wr_low = cyc;
    if (mrw_ok_o !== 1'b1)
      mrw_low = cyc;
  end
  //--------------------------------
  // shared tasks
  //--------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic mode_reg_read_cmd(input logic [7:0] ma, output logic [7:0] d, output logic e, output logic c);
    @(posedge clk_sys_i);
    #1;
    req_valid_i = 1'b1;
    req_ma_i = ma;
    for (int n = 0; n < 200 && req_ready_o !== 1'b1; n++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    #1;
    req_valid_i = 1'b0;
    for (int n = 0; n < 100 && rsp_valid_o !== 1'b1; n++) @(negedge clk_sys_i);
    chk("rsp_valid", 1, rsp_valid_o);
    d = rsp_data_o;
    e = rsp_err_o;
    c = rsp_cal_ok_o;
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  //--------------------------------
  // scenarios
  //--------------------------------
  task automatic t_plain();
    logic [7:0] d;
    logic e, c;
    mode_reg_read_cmd(8'h05, d, e, c);
    chk("read_data", 8'h05 ^ 8'h3C, d);
    chk("strobe_err", 0, e);
    chk("write_gap", 1, wr_low >= cmd_cyc + CK_DIV * MRR_TO_WR_CK - 1);
    chk("mrw_gap", 1, mrw_low >= cmd_cyc + CK_DIV * MRR_TO_WR_CK - 1);
    chk("ck_pair", 1, ck_c_o === ~ck_t_o);
    $display("done: plain read");
  endtask
  task automatic t_cal();
    logic [7:0] d;
    logic e, c;
    mode_reg_read_cmd(MA_CAL_A, d, e, c);
    chk("pattern_a", {8{PAT_A[0]}}, d);
    chk("cal_ok_a", 1, c);
    mode_reg_read_cmd(MA_CAL_B, d, e, c);
    chk("pattern_b", {8{PAT_B[0]}}, d);
    chk("cal_ok_b", 1, c);
    $display("done: calibration");
  endtask
  task automatic t_temp(input logic [2:0] t, input logic hot);
    temp = t;
    for (int n = 0; n < 3 * POLL && temp_status_o !== t; n++) @(negedge clk_sys_i);
    chk("temp_code", t, temp_status_o);
    chk("hot_flag", hot, temp_hot_o);
    $display("done: temperature poll");
  endtask
  task automatic t_refuse();
    logic [7:0] d, n0;
    logic e, c;
    banks_idle_i = 1'b0;
    n0 = mrr_cnt;
    mode_reg_read_cmd(MA_CAL_A, d, e, c);
    chk("cal_refused", 1, e);
    chk("cal_on_pins", n0, mrr_cnt);
    mode_reg_read_cmd(MA_TEMP, d, e, c);
    chk("temp_read", {5'h00, temp}, d);
    chk("temp_read_err", 0, e);
    banks_idle_i = 1'b1;
    $display("done: refusal");
  endtask
  task automatic t_mute();
    logic [7:0] d;
    logic e, c;
    mute = 1'b1;
    mode_reg_read_cmd(8'h01, d, e, c);
    chk("mute_err", 1, e);
    mute = 1'b0;
    $display("done: silent strobes");
  endtask
  task automatic t_space(input logic wr, input logic [4:0] bl, input int need);
    int note;
    logic [7:0] d;
    logic e, c;
    @(posedge clk_sys_i);
    #1;
    rd_cmd_i = !wr;
    wr_cmd_i = wr;
    bl_eff_i = bl;
    note = cyc;
    cmd_cyc = 0;
    @(posedge clk_sys_i);
    #1;
    rd_cmd_i = 1'b0;
    wr_cmd_i = 1'b0;
    mode_reg_read_cmd(8'h06, d, e, c);
    chk("mrr_spacing", 1, cmd_cyc - note >= need);
    $display("done: spacing after burst");
  endtask
  //--------------------------------
  // sequence and watchdog
  //--------------------------------
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk("cs_n_reset", 1, link_o.cs_n);
    chk("ca_reset", NOP_CA, link_o.ca);
    chk("wr_ok_reset", 1, wr_ok_o);
    chk("ck_c_reset", 1, ck_c_o);
    repeat (10) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    t_plain();
    t_cal();
    t_temp(3'h3, 1'b1);
    t_temp(3'h2, 1'b0);
    t_refuse();
    t_mute();
    t_space(1'b0, 5'h10, CK_DIV * 16 / 2);
    t_space(1'b1, 5'h02, CK_DIV * (WL_CK + 1 + 2 / 2 + RU_WTR));
    chk("nop_window", 0, viol_cnt);
    end_sim();
  end
  initial begin
    repeat (LIMIT) @(posedge clk_sys_i);
    err_count++;
    end_sim();
  end
endmodule
